//--- hdl/drsr_pkg.sv
package drsr_pkg;
  localparam int unsigned clk_period_ps = 8000;
  // minimum refresh cycle time
  localparam int unsigned refresh_cycle_ps = 160000;
  localparam int unsigned refresh_cycle_cycles =
    (refresh_cycle_ps + clk_period_ps - 1) / clk_period_ps;
  // average refresh interval, used by the self-refresh timer
  localparam int unsigned refresh_interval_ns = 7800;
  localparam int unsigned refresh_interval_cycles =
    (refresh_interval_ns * 1000) / clk_period_ps;
  // minimum clock-enable pulse time
  localparam int unsigned cke_min_ps = 5000;
  localparam int unsigned cke_min_cycles =
    ((cke_min_ps + clk_period_ps - 1) / clk_period_ps) < 1 ? 1 :
    ((cke_min_ps + clk_period_ps - 1) / clk_period_ps);
  localparam int unsigned row_bits = 14;
  localparam int unsigned col_bits = 10;
  localparam int unsigned addr_bits = 15;
  localparam int unsigned burst_sel_bit = 12;
  localparam int unsigned auto_pre_bit = 10;
  localparam logic [13:0] row_reset = 14'h0000;

  typedef enum logic [1:0] {drsr_cmd_none, drsr_cmd_rd, drsr_cmd_wr} drsr_acc_t;

  // command pins, cs_n, ras_n, cas_n and we_n active low; cke and odt active high
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [addr_bits-1:0] addr;
  } drsr_cmd_t;

  // decoded column access handed to the array side
  typedef struct packed {
    drsr_acc_t kind;
    logic chopped_four_beat_burst;
    logic auto_precharge;
    logic [col_bits-1:0] column;
  } drsr_access_t;
endpackage

//--- hdl/drsr_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
// interval timer for self-refresh, counts only while run is high and cleared otherwise
module drsr_refresh_timer
  import drsr_pkg::*;
#(
  parameter int unsigned interval = refresh_interval_cycles
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic kick,
  output logic tick
);
  logic [15:0] count;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!run || kick)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'(interval - 1))
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hdl/drsr_core.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - burst-select low chops to four, high eight
// - burst-select never part of column address
// - bad write strobes only corrupt addressed data
// - refresh decoded from pins, one per command
// - refresh rows come from internal counter
// - refresh completion leaves banks precharged idle
// - self-refresh entry decoded with cke low
// - stay in self-refresh while cke low
// - loop off on entry, reset on exit
// - ignore inputs, gate clock, refresh internally
// - termination off, pin ignored in self-refresh
module drsr_core
  import drsr_pkg::*;
#(
  parameter int unsigned interval = refresh_interval_cycles
)
(
  input wire logic clk,
  input wire logic reset,
  input wire drsr_cmd_t cmd_pins,
  input wire logic dll_enable,
  input wire logic write_strobe_fault,
  output drsr_access_t access,
  output logic access_valid,
  output logic write_corrupt,
  output logic refresh_busy,
  output logic [row_bits-1:0] refresh_row,
  output logic refresh_row_valid,
  output logic banks_idle,
  output logic self_refresh,
  output logic clock_gated,
  output logic dll_on,
  output logic dll_reset,
  output logic termination_on
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  drsr_cmd_t pins_meta;
  drsr_cmd_t pins;
  logic fault_meta;
  logic fault;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pins_meta <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                     odt: 1'b0, addr: '0};
      pins <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                odt: 1'b0, addr: '0};
      fault_meta <= 1'b0;
      fault <= 1'b0;
    end
    else
    begin
      pins_meta <= cmd_pins;
      pins <= pins_meta;
      fault_meta <= write_strobe_fault;
      fault <= fault_meta;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  function automatic logic is_code(drsr_cmd_t p, logic ras_n, logic cas_n, logic we_n);
    return !p.cs_n && p.ras_n == ras_n && p.cas_n == cas_n && p.we_n == we_n;
  endfunction

  typedef enum {st_idle, st_refresh, st_self} drsr_state_t;
  drsr_state_t state;
  logic [7:0] rfc_count;
  logic [7:0] cke_count;
  logic timer_tick;

  logic dec_refresh;
  logic dec_sr_entry;
  logic dec_read;
  logic dec_write;
  assign dec_refresh = state == st_idle && pins.cke && is_code(pins, 1'b0, 1'b0, 1'b1);
  assign dec_sr_entry = state == st_idle && !pins.cke && is_code(pins, 1'b0, 1'b0, 1'b1);
  assign dec_read = state == st_idle && pins.cke && is_code(pins, 1'b1, 1'b0, 1'b1);
  assign dec_write = state == st_idle && pins.cke && is_code(pins, 1'b1, 1'b0, 1'b0);

  // ----------------------------------------
  // column access
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      access <= '{kind: drsr_cmd_none, chopped_four_beat_burst: 1'b0,
                  auto_precharge: 1'b0, column: '0};
      access_valid <= 1'b0;
    end
    else
    begin
      access_valid <= dec_read || dec_write;
      if (dec_read || dec_write)
      begin
        access.kind <= dec_read ? drsr_cmd_rd : drsr_cmd_wr;
        access.chopped_four_beat_burst <= !pins.addr[burst_sel_bit];
        access.auto_precharge <= pins.addr[auto_pre_bit];
        access.column <= pins.addr[col_bits-1:0];
      end
    end
  end

  // strobe faults only flag the current write; nothing else stops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      write_corrupt <= 1'b0;
    else
      write_corrupt <= dec_write && fault;
  end

  // ----------------------------------------
  // refresh / self-refresh state
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= st_idle;
      rfc_count <= 8'h00;
      cke_count <= 8'h00;
    end
    else
    begin
      case (state)
        st_idle:
        begin
          if (dec_refresh)
          begin
            state <= st_refresh;
            rfc_count <= 8'(refresh_cycle_cycles - 1);
          end
          else if (dec_sr_entry)
          begin
            state <= st_self;
            rfc_count <= 8'(refresh_cycle_cycles - 1);
            cke_count <= 8'h00;
          end
        end
        st_refresh:
        begin
          if (rfc_count == 8'h00)
            state <= st_idle;
          else
            rfc_count <= rfc_count - 8'h01;
        end
        st_self:
        begin
          if (cke_count != 8'hff)
            cke_count <= cke_count + 8'h01;
          if (rfc_count != 8'h00)
            rfc_count <= rfc_count - 8'h01;
          else if (timer_tick)
            rfc_count <= 8'(refresh_cycle_cycles - 1);
          if (pins.cke && cke_count >= 8'(cke_min_cycles))
            state <= st_idle;
        end
        default:
          state <= st_idle;
      endcase
    end
  end

  drsr_refresh_timer #(
    .interval(interval)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .run(state == st_self),
    .kick(1'b0),
    .tick(timer_tick)
  );

  // ----------------------------------------
  // internal refresh row counter
  // ----------------------------------------
  logic start_row;
  assign start_row = dec_refresh || dec_sr_entry || (state == st_self && rfc_count == 8'h00 &&
                     timer_tick);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      refresh_row <= row_reset;
      refresh_row_valid <= 1'b0;
    end
    else
    begin
      refresh_row_valid <= start_row;
      if (start_row)
        refresh_row <= refresh_row + 14'h0001;
    end
  end

  // ----------------------------------------
  // status, loop and termination
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      refresh_busy <= 1'b0;
      banks_idle <= 1'b1;
      self_refresh <= 1'b0;
      clock_gated <= 1'b0;
      dll_on <= 1'b0;
      dll_reset <= 1'b0;
      termination_on <= 1'b0;
    end
    else
    begin
      refresh_busy <= state == st_refresh || (state == st_self && rfc_count != 8'h00);
      banks_idle <= state != st_refresh;
      self_refresh <= state == st_self;
      clock_gated <= state == st_self;
      dll_on <= dll_enable && state != st_self;
      dll_reset <= dll_enable && state == st_self && pins.cke &&
                   cke_count >= 8'(cke_min_cycles);
      termination_on <= state != st_self && !dec_sr_entry && pins.odt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_sr_entry;
    dec_sr_entry;
  endsequence

  sequence s_sr_held;
    self_refresh ##1 self_refresh;
  endsequence

  a_burst_chop_low: assert property (@(posedge clk) disable iff (reset)
    (dec_read || dec_write) |=> access.chopped_four_beat_burst == !$past(pins.addr[12]))
    else $error("burst size not taken from burst select");
  a_column_no_bsel: assert property (@(posedge clk) disable iff (reset)
    (dec_read || dec_write) |=> access.column == $past(pins.addr[9:0]))
    else $error("column address wrong");
  a_refresh_enter: assert property (@(posedge clk) disable iff (reset)
    dec_refresh |=> state == st_refresh ##0 refresh_row_valid)
    else $error("refresh command not taken");
  a_refresh_done_idle: assert property (@(posedge clk) disable iff (reset)
    dec_refresh |=> ##[1:30] (state == st_idle))
    else $error("refresh did not finish");
  a_row_advance: assert property (@(posedge clk) disable iff (reset)
    refresh_row_valid |-> refresh_row == $past(refresh_row) + 14'h0001)
    else $error("refresh row did not advance");
  a_sr_entry_state: assert property (@(posedge clk) disable iff (reset)
    s_sr_entry |=> ##1 s_sr_held)
    else $error("self-refresh entry not held");
  a_sr_ignore_cmd: assert property (@(posedge clk) disable iff (reset)
    self_refresh |-> !access_valid && clock_gated)
    else $error("command accepted in self-refresh");
  a_dll_off_sr: assert property (@(posedge clk) disable iff (reset)
    self_refresh |-> !dll_on)
    else $error("loop left running in self-refresh");
  a_odt_off_sr: assert property (@(posedge clk) disable iff (reset)
    state == st_self |=> !termination_on)
    else $error("termination on in self-refresh");
  a_sr_min_stay: assert property (@(posedge clk) disable iff (reset)
    $rose(self_refresh) |=> self_refresh)
    else $error("left self-refresh too early");
  a_write_fault: assert property (@(posedge clk) disable iff (reset)
    write_corrupt |-> access_valid && access.kind == drsr_cmd_wr)
    else $error("corruption flagged outside a write");
endmodule
`default_nettype wire

//--- bench/drsr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: encodes pin levels from an op code
module drsr_ctrl_model
  import drsr_pkg::*;
(
  input wire logic [1:0] op,
  input wire logic cke,
  input wire logic odt,
  input wire logic [addr_bits-1:0] addr,
  output drsr_cmd_t cmd_pins
);
  // op 0 nop, 1 read, 2 write, 3 refresh or self-refresh entry with cke low
  always_comb
  begin
    cmd_pins.cke = cke;
    cmd_pins.odt = odt;
    cmd_pins.cs_n = 1'b0;
    cmd_pins.ras_n = (op != 2'h3);
    cmd_pins.cas_n = (op == 2'h0);
    cmd_pins.we_n = (op != 2'h2);
    // released address bus shows the inverse of the last value
    cmd_pins.addr = (op == 2'h0) ? ~addr : addr;
  end
endmodule
`default_nettype wire

//--- bench/dram_refresh_and_self_refresh_test.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_and_self_refresh_test
  import drsr_pkg::*;
;
  logic clk = 0, reset = 1, cke = 1, odt = 0, dll_enable = 1, write_strobe_fault = 0;
  logic [1:0] op = 2'h0;
  logic [addr_bits-1:0] addr = '0, a;
  drsr_cmd_t cmd_pins;
  drsr_access_t access, exp;
  logic access_valid, write_corrupt, refresh_busy, refresh_row_valid, banks_idle;
  logic self_refresh, clock_gated, dll_on, dll_reset, termination_on, seen;
  logic [row_bits-1:0] refresh_row;
  integer miscompares = 0, n_tests = 0, seed = 46, cycles = 0;
  integer n_rows = 0, n_acc = 0, k, debt = 0;

  drsr_ctrl_model partner (.op(op), .cke(cke), .odt(odt), .addr(addr), .cmd_pins(cmd_pins));
  drsr_core #(.interval(20)) dut (.clk(clk), .reset(reset), .cmd_pins(cmd_pins),
    .dll_enable(dll_enable), .write_strobe_fault(write_strobe_fault), .access(access),
    .access_valid(access_valid), .write_corrupt(write_corrupt), .refresh_busy(refresh_busy),
    .refresh_row(refresh_row), .refresh_row_valid(refresh_row_valid), .banks_idle(banks_idle),
    .self_refresh(self_refresh), .clock_gated(clock_gated), .dll_on(dll_on),
    .dll_reset(dll_reset), .termination_on(termination_on));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // compare tasks and verdict
  // ----------------------------------------
  task automatic bad(input string what);
    miscompares++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic chk_flag(input logic got, input logic want, input string what);
    n_tests++;
    if (got !== want)
      bad(what);
  endtask

  task automatic chk_acc(input drsr_access_t want, input logic corrupt);
    n_tests++;
    if (access_valid !== 1'b1 || access !== want || write_corrupt !== corrupt)
      bad("column access decode");
  endtask

  task automatic chk_row(input logic [row_bits-1:0] want);
    n_tests++;
    if (refresh_row !== want)
      bad("refresh row step");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one-cycle command, then nop; returns at the falling edge after its edge
  task automatic issue(input logic [1:0] o, input logic k_en, input logic [addr_bits-1:0] ad);
    @(negedge clk);
    op = o;
    cke = k_en;
    addr = ad;
    // refresh debt: early refreshes earn credit down to eight only
    if (o == 2'h3 && k_en && debt > -8)
      debt--;
    @(negedge clk);
    op = 2'h0;
  endtask

  // ----------------------------------------
  // reference model of the internal row counter
  // ----------------------------------------
  always @(negedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad("timeout");
      give_verdict;
    end
    if (access_valid === 1'b1)
      n_acc++;
    if (cycles % refresh_interval_cycles == 0)
      debt++;
    if (refresh_row_valid === 1'b1)
    begin
      chk_row(row_reset + row_bits'(n_rows + 1));
      n_rows++;
    end
  end

  initial
  begin
    repeat (10) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 12; i++)
    begin
      a = addr_bits'($random(seed));
      write_strobe_fault = i[0] & 1'($random(seed));
      exp.kind = i[0] ? drsr_cmd_wr : drsr_cmd_rd;
      exp.chopped_four_beat_burst = ~a[burst_sel_bit];
      exp.auto_precharge = a[auto_pre_bit];
      exp.column = a[col_bits-1:0];
      issue(i[0] ? 2'h2 : 2'h1, 1'b1, a);
      repeat (2) @(negedge clk);
      chk_acc(exp, write_strobe_fault);
      write_strobe_fault = 0;
    end
    for (int i = 0; i < 3; i++)
    begin
      k = n_rows;
      chk_flag(banks_idle, 1'b1, "banks idle before refresh");
      issue(2'h3, 1'b1, addr_bits'($random(seed)));
      repeat (3) @(negedge clk);
      chk_flag(n_rows == k + 1, 1'b1, "refresh row pulse");
      @(negedge clk);
      chk_flag(refresh_busy, 1'b1, "refresh busy");
      chk_flag(banks_idle, 1'b0, "banks busy in refresh");
      repeat (refresh_cycle_cycles + 3) @(negedge clk);
      chk_flag(banks_idle, 1'b1, "banks idle after refresh");
      chk_flag(refresh_busy, 1'b0, "refresh finished");
    end
    // second round re-enters with the loop disabled
    for (int r = 0; r < 2; r++)
    begin
      dll_enable = (r == 0);
      if (r == 1)
      begin
        repeat (refresh_cycle_cycles + 2) @(negedge clk);
        issue(2'h3, 1'b1, addr_bits'($random(seed)));
        repeat (refresh_cycle_cycles + 6) @(negedge clk);
      end
      odt = 1;
      repeat (4) @(negedge clk);
      chk_flag(termination_on, 1'b1, "termination follows pin");
      odt = 0;
      repeat (4) @(negedge clk);
      chk_flag(dll_on, dll_enable, "loop before entry");
      chk_flag(debt <= 0 && debt >= -8, 1'b1, "refresh debt settled");
      k = n_rows;
      issue(2'h3, 1'b0, addr_bits'($random(seed)));
      repeat (4) @(negedge clk);
      chk_flag(self_refresh, 1'b1, "self refresh entered");
      chk_flag(clock_gated, 1'b1, "clock gated");
      chk_flag(dll_on, 1'b0, "loop off");
      chk_flag(termination_on, 1'b0, "termination off");
      chk_flag(n_rows > k, 1'b1, "refresh at entry");
      odt = 1;
      op = 2'h1;
      repeat (45) @(negedge clk);
      op = 2'h0;
      chk_flag(n_acc == 12, 1'b1, "inputs ignored");
      chk_flag(n_rows >= k + 3, 1'b1, "timer refreshes");
      chk_flag(self_refresh, 1'b1, "stays while cke low");
      chk_flag(termination_on, 1'b0, "pin ignored in self refresh");
      odt = 0;
      cke = 1;
      seen = 0;
      repeat (6)
      begin
        @(negedge clk);
        seen = seen | (dll_reset === 1'b1);
      end
      chk_flag(seen, dll_enable, "loop reset on exit");
      chk_flag(self_refresh, 1'b0, "self refresh left");
      chk_flag(dll_on, dll_enable, "loop back on");
      chk_flag(clock_gated, 1'b0, "clock running");
    end
    give_verdict;
  end
endmodule
`default_nettype wire
